// [regulator_control_defines.svh]
// Contract
// - Startup to Active: each core switcher ramps in code steps up to 1.235V.
// - Unloaded ramp ends near 120 us; a fully loaded one near 135 us.
// - Current-limit fault stops switching until load falls and the fault clears.
// - A linear regulator at its current-limit trip has its pass element off.
// - The I/O regulator powers the bus drivers; the host keeps it on or drives it.
// - Option bit 4 of the first slave turns the I/O regulator off.
// - Low-bias bit 0 resets clear (50 mA); set gives 5 mA and less bias, except with tracking set outside Sleep (50 mA).
// - Tracking bit 1 per slave: first LDO follows core one, second follows core two.
// - Tracking clear: memory LDO holds the memory level value while Active.
// - Tracking set: memory LDO follows its core switcher about 25 mV above.
// - 5 mA when low-bias set and tracking clear or Sleep; otherwise 50 mA.
// - Slew bit 2 set limits core output rate of change; clear moves at full speed.
// - Bit 3 of the first slave: set open-drain outputs (reset), clear push-pull.
// - On Sleep the core turns off after 32 us; LDO then goes to retention level.
`ifndef REGULATOR_CONTROL_DEFINES_SVH
`define REGULATOR_CONTROL_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS     25
`define SOFTSTART_TIME_NS 120000
`define RAMP_STEPS        128
`define STEP_CYCLES       ((`SOFTSTART_TIME_NS / `CLK_PERIOD_NS) / `RAMP_STEPS)
`define SLEEP_DELAY_NS    32000
`define SLEEP_CYCLES      (`SLEEP_DELAY_NS / `CLK_PERIOD_NS)
`define SLEW_STEP_CYCLES  `STEP_CYCLES

// ----------------------------------------
// Codes
// ----------------------------------------
`define CODE_ZERO 7'h00
`define CODE_MAX  7'h7F

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CORE_LEVEL_ADDR 5'h00
`define MEM_LEVEL_ADDR  5'h01
`define RET_LEVEL_ADDR  5'h02
`define OPTION_ADDR     5'h0A
`define TRACK_ADDR      5'h0D
`define STATUS_ADDR     5'h1F

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define OPT_IO_OFF_BIT    4
`define TRK_LOWBIAS_BIT   0
`define TRK_TRACK_BIT     1
`define TRK_SLEW_BIT      2
`define TRK_OPENDRAIN_BIT 3
`define CORE_LEVEL_RESET  8'h7F
`define MEM_LEVEL_RESET   8'h00
`define RET_LEVEL_RESET   8'h00
`define OPTION_RESET      8'h00
`define TRACK0_RESET      8'h08
`define TRACK1_RESET      8'h00

`endif

// [regulator_control_pkg.sv]
package regulator_control_pkg;
	typedef enum logic [1:0] {
		SLAVE_STARTUP  = 2'b00,
		SLAVE_ACTIVE   = 2'b01,
		SLAVE_SLEEP    = 2'b11,
		SLAVE_SHUTDOWN = 2'b10
	} slave_state_type;

	typedef enum logic [1:0] {
		CORE_OFF   = 2'b00,
		CORE_RAMP  = 2'b01,
		CORE_ON    = 2'b11,
		CORE_SLEEP = 2'b10
	} core_state_type;

	typedef enum logic [2:0] {
		LDO_OFF        = 3'b000,
		LDO_POR        = 3'b001,
		LDO_PROGRAMMED = 3'b011,
		LDO_TRACK      = 3'b010,
		LDO_RETAIN     = 3'b110
	} ldo_mode_type;
endpackage

// [channel_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface channel_if;
	import regulator_control_pkg::*;
	slave_state_type slave_state;
	logic            fault;
	logic [6:0]      target_code;
	logic            track;
	logic            slew;
	logic            lowbias;
	logic [6:0]      core_code;
	logic            core_switch_en;
	logic            ramp_done;
	ldo_mode_type    ldo_mode;
	logic            ldo_high_cap;

	modport channel (
		input  slave_state, fault, target_code, track, slew, lowbias,
		output core_code, core_switch_en, ramp_done, ldo_mode, ldo_high_cap
	);
	modport owner (
		output slave_state, fault, target_code, track, slew, lowbias,
		input  core_code, core_switch_en, ramp_done, ldo_mode, ldo_high_cap
	);
endinterface
`default_nettype wire

// [core_channel.sv]
`timescale 1ns/1ps
`default_nettype none
`include "regulator_control_defines.svh"
module core_channel
	import regulator_control_pkg::*;
(
	// Clock and reset
	input wire logic   clk,
	input wire logic   arst_n,
	// Slave side
	channel_if.channel ch
);
	core_state_type state_reg;
	logic [10:0]    cnt_reg;

	// ----------------------------------------
	// Core sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg    <= CORE_OFF;
			cnt_reg      <= 11'h000;
			ch.core_code <= `CODE_ZERO;
		end else begin
			case (state_reg)
				CORE_OFF: begin
					cnt_reg      <= 11'h000;
					ch.core_code <= `CODE_ZERO;
					if (ch.slave_state == SLAVE_ACTIVE) begin
						state_reg <= CORE_RAMP;
					end
				end
				CORE_RAMP: begin
					if (ch.slave_state == SLAVE_SLEEP) begin
						state_reg    <= CORE_SLEEP;
						cnt_reg      <= 11'h000;
						ch.core_code <= `CODE_ZERO;
					end else if (ch.slave_state != SLAVE_ACTIVE) begin
						state_reg <= CORE_OFF;
					end else if (ch.core_code == `CODE_MAX) begin
						state_reg <= CORE_ON;
					end else if (!ch.fault) begin
						// Ramp pauses while current limit holds the switcher
						if (cnt_reg == 11'(`STEP_CYCLES - 1)) begin
							cnt_reg      <= 11'h000;
							ch.core_code <= ch.core_code + 7'h01;
						end else begin
							cnt_reg <= cnt_reg + 11'h001;
						end
					end
				end
				CORE_ON: begin
					if (ch.slave_state == SLAVE_SLEEP) begin
						state_reg    <= CORE_SLEEP;
						cnt_reg      <= 11'h000;
						ch.core_code <= `CODE_ZERO;
					end else if (ch.slave_state != SLAVE_ACTIVE) begin
						state_reg <= CORE_OFF;
					end else if (!ch.slew) begin
						ch.core_code <= ch.target_code;
					end else if (ch.core_code == ch.target_code) begin
						cnt_reg <= 11'h000;
					end else if (cnt_reg == 11'(`SLEW_STEP_CYCLES - 1)) begin
						// One code per interval so the tracking LDO keeps up
						cnt_reg <= 11'h000;
						if (ch.target_code > ch.core_code) begin
							ch.core_code <= ch.core_code + 7'h01;
						end else begin
							ch.core_code <= ch.core_code - 7'h01;
						end
					end else begin
						cnt_reg <= cnt_reg + 11'h001;
					end
				end
				CORE_SLEEP: begin
					if (ch.slave_state == SLAVE_ACTIVE) begin
						state_reg <= CORE_RAMP;
						cnt_reg   <= 11'h000;
					end else if (ch.slave_state != SLAVE_SLEEP) begin
						state_reg <= CORE_OFF;
					end else if (cnt_reg != 11'(`SLEEP_CYCLES - 1)) begin
						cnt_reg <= cnt_reg + 11'h001;
					end
				end
				default: begin
					state_reg <= CORE_OFF;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Switcher and memory LDO outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ch.core_switch_en <= 1'b0;
			ch.ramp_done      <= 1'b0;
			ch.ldo_mode       <= LDO_OFF;
			ch.ldo_high_cap   <= 1'b1;
		end else begin
			ch.core_switch_en <= ((state_reg == CORE_RAMP) || (state_reg == CORE_ON) ||
				((state_reg == CORE_SLEEP) && (cnt_reg != 11'(`SLEEP_CYCLES - 1)))) &&
				!ch.fault;
			ch.ramp_done <= (state_reg == CORE_ON);
			case (state_reg)
				CORE_ON:    ch.ldo_mode <= ch.track ? LDO_TRACK : LDO_PROGRAMMED;
				CORE_RAMP:  ch.ldo_mode <= LDO_POR;
				CORE_SLEEP: ch.ldo_mode <= (cnt_reg == 11'(`SLEEP_CYCLES - 1)) ? LDO_RETAIN : LDO_POR;
				default:    ch.ldo_mode <= LDO_OFF;
			endcase
			ch.ldo_high_cap <= !(ch.lowbias &&
				(!ch.track || (ch.slave_state == SLAVE_SLEEP)));
		end
	end
endmodule
`default_nettype wire

// [regulator_tracking_softstart_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "regulator_control_defines.svh"
module regulator_tracking_softstart_control
	import regulator_control_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            arst_n,
	// Decoded register access
	input  wire logic            reg_wr_en,
	input  wire logic            reg_rd_en,
	input  wire logic            reg_slave,
	input  wire logic [4:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	output var  logic [7:0]      reg_rdata,
	// Slave states
	input  wire slave_state_type slave_state [2],
	// Analog current-limit pins
	input  wire logic [1:0]      core_fault_pin,
	input  wire logic [1:0]      mem_ldo_trip_pin,
	input  wire logic            io_ldo_trip_pin,
	// Core switchers
	output var  logic [1:0][6:0] core_code,
	output var  logic [1:0]      core_switch_en,
	// Memory LDOs
	output var  ldo_mode_type    mem_ldo_mode [2],
	output var  logic [1:0][7:0] mem_ldo_level,
	output var  logic [1:0]      mem_ldo_pass_en,
	output var  logic [1:0]      mem_ldo_high_cap,
	// I/O regulator and general outputs
	output var  logic            io_ldo_pass_en,
	output var  logic            general_outputs_open_drain
);
	logic [1:0][7:0] core_level_reg;
	logic [1:0][7:0] memory_level_reg;
	logic [1:0][7:0] retention_level_reg;
	logic [1:0][7:0] regulator_option_reg;
	logic [1:0][7:0] tracking_config_reg;
	logic [4:0]      sync1_reg;
	logic [4:0]      sync2_reg;
	logic [1:0]      ramp_done;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end else begin
			sync1_reg <= {io_ldo_trip_pin, mem_ldo_trip_pin, core_fault_pin};
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_level_reg       <= {2{`CORE_LEVEL_RESET}};
			memory_level_reg     <= {2{`MEM_LEVEL_RESET}};
			retention_level_reg  <= {2{`RET_LEVEL_RESET}};
			regulator_option_reg <= {2{`OPTION_RESET}};
			tracking_config_reg  <= {`TRACK1_RESET, `TRACK0_RESET};
		end else if (reg_wr_en) begin
			case (reg_addr)
				`CORE_LEVEL_ADDR: core_level_reg[reg_slave]       <= reg_wdata;
				`MEM_LEVEL_ADDR:  memory_level_reg[reg_slave]     <= reg_wdata;
				`RET_LEVEL_ADDR:  retention_level_reg[reg_slave]  <= reg_wdata;
				`OPTION_ADDR:     regulator_option_reg[reg_slave] <= reg_wdata;
				`TRACK_ADDR:      tracking_config_reg[reg_slave]  <= reg_wdata;
				default:          core_level_reg                  <= core_level_reg;
			endcase
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd_en) begin
			case (reg_addr)
				`CORE_LEVEL_ADDR: reg_rdata <= core_level_reg[reg_slave];
				`MEM_LEVEL_ADDR:  reg_rdata <= memory_level_reg[reg_slave];
				`RET_LEVEL_ADDR:  reg_rdata <= retention_level_reg[reg_slave];
				`OPTION_ADDR:     reg_rdata <= regulator_option_reg[reg_slave];
				`TRACK_ADDR:      reg_rdata <= tracking_config_reg[reg_slave];
				`STATUS_ADDR:     reg_rdata <= {3'h0, ramp_done[reg_slave], core_switch_en[reg_slave],
					sync2_reg[4], sync2_reg[2 + reg_slave], sync2_reg[reg_slave]};
				default:          reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Per-slave channels
	// ----------------------------------------
	for (genvar g = 0; g < 2; g++) begin : gen_slave
		channel_if ch ();
		assign ch.slave_state = slave_state[g];
		assign ch.fault       = sync2_reg[g];
		assign ch.target_code = core_level_reg[g][6:0];
		assign ch.track       = tracking_config_reg[g][`TRK_TRACK_BIT];
		assign ch.slew        = tracking_config_reg[g][`TRK_SLEW_BIT];
		assign ch.lowbias     = tracking_config_reg[g][`TRK_LOWBIAS_BIT];
		assign core_code[g]        = ch.core_code;
		assign core_switch_en[g]   = ch.core_switch_en;
		assign ramp_done[g]        = ch.ramp_done;
		assign mem_ldo_mode[g]     = ch.ldo_mode;
		assign mem_ldo_high_cap[g] = ch.ldo_high_cap;

		core_channel u_channel (
			.clk    (clk),
			.arst_n (arst_n),
			.ch     (ch.channel)
		);

		// Retention value only once the core is off in Sleep
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				mem_ldo_level[g]   <= `MEM_LEVEL_RESET;
				mem_ldo_pass_en[g] <= 1'b0;
			end else begin
				mem_ldo_level[g]   <= (ch.ldo_mode == LDO_RETAIN) ?
					retention_level_reg[g] : memory_level_reg[g];
				mem_ldo_pass_en[g] <= (ch.ldo_mode != LDO_OFF) && !sync2_reg[2 + g];
			end
		end
	end

	// ----------------------------------------
	// Shared I/O supply and general outputs
	// ----------------------------------------
	// Turning the I/O regulator off cuts the bus unless the host back-drives it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			io_ldo_pass_en             <= 1'b1;
			general_outputs_open_drain <= 1'b1;
		end else begin
			io_ldo_pass_en <= !regulator_option_reg[0][`OPT_IO_OFF_BIT] && !sync2_reg[4];
			general_outputs_open_drain <= tracking_config_reg[0][`TRK_OPENDRAIN_BIT];
		end
	end
endmodule
`default_nettype wire

// [host_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	// Clock
	input  wire logic       clk,
	// Register access
	output var  logic       reg_wr_en,
	output var  logic       reg_rd_en,
	output var  logic       reg_slave,
	output var  logic [4:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// ----------
	// Host access
	// ----------
	// I/O option bit only changes when a scenario commands it
	// Tracking bits are host guidance, the model does not police them
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_slave = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic s, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr_en <= 1'b1;
		reg_slave <= s;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic s, input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd_en <= 1'b1;
		reg_slave <= s;
		reg_addr <= a;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// [regulator_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "regulator_control_defines.svh"
module regulator_checker
	import regulator_control_pkg::*;
(
	// Clock and reset
	input wire logic            clk,
	input wire logic            arst_n,
	// Register access
	input wire logic            reg_wr_en,
	input wire logic            reg_rd_en,
	input wire logic            reg_slave,
	input wire logic [4:0]      reg_addr,
	input wire logic [7:0]      reg_wdata,
	input wire logic [7:0]      reg_rdata,
	// Pins and states
	input wire slave_state_type slave_state [2],
	input wire logic [1:0]      core_fault_pin,
	input wire logic [1:0]      mem_ldo_trip_pin,
	input wire logic            io_ldo_trip_pin,
	// Regulator outputs
	input wire logic [1:0][6:0] core_code,
	input wire logic [1:0]      core_switch_en,
	input wire ldo_mode_type    mem_ldo_mode [2],
	input wire logic [1:0][7:0] mem_ldo_level,
	input wire logic [1:0]      mem_ldo_pass_en,
	input wire logic [1:0]      mem_ldo_high_cap,
	input wire logic            io_ldo_pass_en,
	input wire logic            general_outputs_open_drain
);
	logic [1:0][7:0] trk_reg;
	logic            io_off_reg;
	logic [7:0]      rd_exp_reg;
	logic [12:0]     st_cnt_reg;
	logic [1:0]      cfg_cnt_reg;
	slave_state_type st_q_reg;
	logic            cap_exp;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	assign cap_exp = !(trk_reg[0][0] && (!trk_reg[0][1] || slave_state[0] == SLAVE_SLEEP));
	// ----------
	// Shadow state
	// ----------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trk_reg <= {`TRACK1_RESET, `TRACK0_RESET};
			io_off_reg <= 1'b0;
			rd_exp_reg <= 8'h00;
		end else begin
			if (reg_wr_en && reg_addr == `TRACK_ADDR) trk_reg[reg_slave] <= reg_wdata;
			if (reg_wr_en && reg_addr == `OPTION_ADDR && !reg_slave) io_off_reg <= reg_wdata[4];
			if (reg_rd_en) rd_exp_reg <= trk_reg[reg_slave];
		end
	end
	// Ramp counter restarts only on a state change, so writes cannot fake a fresh ramp
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q_reg <= SLAVE_STARTUP;
			st_cnt_reg <= 13'h0000;
			cfg_cnt_reg <= 2'h0;
		end else begin
			st_q_reg <= slave_state[0];
			st_cnt_reg <= (slave_state[0] != st_q_reg) ? 13'h0000 : st_cnt_reg + 13'(st_cnt_reg != 13'h1FFF);
			cfg_cnt_reg <= reg_wr_en ? 2'h0 : cfg_cnt_reg + 2'(cfg_cnt_reg != 2'h3);
		end
	end
	// ----------
	// Assertions
	// ----------
	AST_RAMP_EARLY: assert property (slave_state[0] == SLAVE_ACTIVE && st_cnt_reg == 13'd4690 |->
		core_code[0] != 7'h7F) else $error("core ramp ended early");
	AST_RAMP_DONE: assert property (slave_state[0] == SLAVE_ACTIVE && st_cnt_reg == 13'd4710
		&& !core_fault_pin[0] |-> core_code[0] == 7'h7F) else $error("core ramp not at full code");
	AST_SLEEP_OFF: assert property (slave_state[0] == SLAVE_SLEEP && st_cnt_reg == 13'd1290 |->
		(!core_switch_en[0] && mem_ldo_mode[0] == LDO_RETAIN)[*3]) else $error("sleep shutdown wrong");
	// State must be settled too: the counter still shows its old value on the edge of a change
	AST_CAPABILITY: assert property (cfg_cnt_reg == 2'h3 && st_cnt_reg > 13'd2 && slave_state[0][0] &&
		slave_state[0] == st_q_reg |->
		mem_ldo_high_cap[0] == cap_exp) else $error("ldo capability wrong");
	AST_LDO_MODE: assert property (slave_state[0] == SLAVE_ACTIVE && st_cnt_reg > 13'd4705 && cfg_cnt_reg == 2'h3
		&& slave_state[0] == st_q_reg
		|-> mem_ldo_mode[0] == (trk_reg[0][1] ? LDO_TRACK : LDO_PROGRAMMED)) else $error("ldo mode wrong");
	AST_CORE_FAULT: assert property (core_fault_pin[1] [*5] |-> !core_switch_en[1]) else $error("switching in fault");
	AST_LDO_TRIP: assert property (mem_ldo_trip_pin[0] [*5] |-> !mem_ldo_pass_en[0]) else $error("ldo on in trip");
	AST_IO_OFF: assert property (io_off_reg && cfg_cnt_reg == 2'h3 |-> !io_ldo_pass_en) else $error("io regulator on");
	AST_OPEN_DRAIN: assert property (cfg_cnt_reg == 2'h3 |->
		general_outputs_open_drain == trk_reg[0][3]) else $error("output type wrong");
	AST_READ: assert property (reg_rd_en && reg_addr == `TRACK_ADDR |=> reg_rdata == rd_exp_reg)
		else $error("tracking read wrong");
endmodule
`default_nettype wire

// [regulator_tracking_softstart_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "regulator_control_defines.svh"
module regulator_tracking_softstart_control_bench
	import regulator_control_pkg::*;
;
	logic clk, arst_n, reg_wr_en, reg_rd_en, reg_slave, io_ldo_trip_pin, io_ldo_pass_en, general_outputs_open_drain;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [1:0] core_fault_pin, mem_ldo_trip_pin, core_switch_en, mem_ldo_pass_en, mem_ldo_high_cap;
	logic [1:0][6:0] core_code;
	logic [1:0][7:0] mem_ldo_level;
	slave_state_type slave_state [2];
	ldo_mode_type mem_ldo_mode [2];
	int miscompares, checks_done;
	host_bus_model host_u (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_slave(reg_slave),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	regulator_tracking_softstart_control dut_u (.*);
	// ----------
	// Helpers
	// ----------
	always #12.5 clk = ~clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic end_sim;
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_reset;
		chk({io_ldo_pass_en, general_outputs_open_drain, mem_ldo_high_cap}, 8'h0F);
		host_u.rd(1'b1, `TRACK_ADDR, d);
		chk(d, `TRACK1_RESET);
		host_u.rd(1'b0, `TRACK_ADDR, d);
		chk(d, `TRACK0_RESET);
		host_u.rd(1'b0, 5'h15, d);
		chk(d, 8'h00);
	endtask
	task automatic t_ramp;
		@(posedge clk) slave_state[0] <= SLAVE_ACTIVE;
		cyc(2400);
		chk(core_code[0] > 7'h30 && core_code[0] < 7'h7F, 8'h01);
		cyc(2320);
		chk(core_code[0], 8'h7F);
		chk(mem_ldo_mode[0], LDO_PROGRAMMED);
		host_u.wr(1'b0, `MEM_LEVEL_ADDR, 8'h35);
		cyc(3);
		chk(mem_ldo_level[0], 8'h35);
		host_u.wr(1'b0, `TRACK_ADDR, 8'h06);
		cyc(3);
		chk({mem_ldo_mode[0], general_outputs_open_drain}, {LDO_TRACK, 1'b0});
		// Slew limited: one code per step interval toward the new level
		host_u.wr(1'b0, `CORE_LEVEL_ADDR, 8'h70);
		cyc(50);
		chk(core_code[0], 8'h7E);
		host_u.wr(1'b0, `TRACK_ADDR, 8'h02);
		cyc(3);
		chk(core_code[0], 8'h70);
	endtask
	task automatic t_sleep;
		host_u.wr(1'b0, `RET_LEVEL_ADDR, 8'h2A);
		@(posedge clk) slave_state[0] <= SLAVE_SLEEP;
		cyc(1300);
		chk({core_switch_en[0], mem_ldo_mode[0]}, {1'b0, LDO_RETAIN});
		chk(mem_ldo_level[0], 8'h2A);
	endtask
	task automatic t_capability;
		for (int i = 0; i < 8; i++) begin
			host_u.wr(1'b0, `TRACK_ADDR, {6'h00, i[2], i[1]});
			@(posedge clk) slave_state[0] <= i[0] ? SLAVE_SLEEP : SLAVE_ACTIVE;
			cyc(4);
			chk(mem_ldo_high_cap[0], 8'(8'h73 >> i) & 8'h01);
		end
	endtask
	task automatic t_fault;
		logic [6:0] c;
		@(posedge clk) slave_state[1] <= SLAVE_ACTIVE;
		cyc(50);
		chk(core_switch_en[1], 8'h01);
		chk({mem_ldo_mode[1], mem_ldo_pass_en[1]}, {LDO_POR, 1'b1});
		@(posedge clk) core_fault_pin[1] <= 1'b1;
		cyc(6);
		c = core_code[1];
		chk(core_switch_en[1], 8'h00);
		cyc(80);
		chk(core_code[1], c);
		@(posedge clk) core_fault_pin[1] <= 1'b0;
		cyc(80);
		chk(core_code[1] > c && core_switch_en[1], 8'h01);
	endtask
	task automatic t_trip;
		@(posedge clk) mem_ldo_trip_pin[0] <= 1'b1;
		io_ldo_trip_pin <= 1'b1;
		cyc(6);
		chk({mem_ldo_pass_en[0], io_ldo_pass_en}, 8'h00);
		@(posedge clk) mem_ldo_trip_pin[0] <= 1'b0;
		io_ldo_trip_pin <= 1'b0;
		cyc(6);
		chk({mem_ldo_pass_en[0], io_ldo_pass_en}, 8'h03);
		host_u.wr(1'b0, `OPTION_ADDR, 8'h10);
		cyc(3);
		chk(io_ldo_pass_en, 8'h00);
		host_u.wr(1'b0, `OPTION_ADDR, 8'h00);
		cyc(3);
		chk(io_ldo_pass_en, 8'h01);
	endtask
	// ----------
	// Main sequence and watchdog
	// ----------
	initial begin
		{clk, arst_n, io_ldo_trip_pin, core_fault_pin, mem_ldo_trip_pin} = '0;
		slave_state = '{SLAVE_STARTUP, SLAVE_STARTUP};
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_ramp();
		t_sleep();
		t_capability();
		t_fault();
		t_trip();
		end_sim();
	end
	initial begin
		#1000000;
		miscompares++;
		end_sim();
	end
endmodule
bind regulator_tracking_softstart_control regulator_checker chk_u (.*);
`default_nettype wire
